/* common/lvrs_map.vh */
// constants for the low-voltage reset and safe-state block
// assumes a 32-bit apb register window, one aligned word per register
`ifndef LVRS_MAP_VH
`define LVRS_MAP_VH

// register byte offsets
`define LVRS_OFS_CTRL 8'h00
`define LVRS_OFS_CAUSE 8'h04
`define LVRS_OFS_ISTAT 8'h08
`define LVRS_OFS_IMASK 8'h0c

// power_mgmt_ctrl1 fields
`define LVRS_CTL_FLAG 0
`define LVRS_CTL_ACK 1
`define LVRS_CTL_IE 2
`define LVRS_CTL_RE 3
`define LVRS_CTL_SAFE 4
`define LVRS_CTL_WARN 5
`define LVRS_CTL_SSTATE 6

// reset_cause_reg fields
`define LVRS_CS_POR 7
`define LVRS_CS_PIN 6
`define LVRS_CS_WDOG 5
`define LVRS_CS_ILOP 4
`define LVRS_CS_ILAD 3
`define LVRS_CS_LVD 1
`define LVRS_CAUSE_W 8
`define LVRS_CAUSE_POR 8'h82

// interrupt status / mask fields
`define LVRS_EV_W 3
`define LVRS_EV_DET 0
`define LVRS_EV_SAFE 1
`define LVRS_EV_REARM 2

// vector addresses
`define LVRS_VEC_RESET 16'hfffe
`define LVRS_VEC_LVD 16'hfffa
`define LVRS_VEC_NONE 16'h0000

// cycles a non-supply reset is stretched
`define LVRS_HOLD_CYC 32

`endif

/* rtl/lvrs_sync.v */
// two-flop synchroniser, one stage pair per bit
// assumes inputs asynchronous to clock_i; reset value is a constant
`timescale 1ns/1ns
module lvrs_sync #(
  parameter W = 1,
  parameter [W-1:0] RSTV = {W{1'b0}}
) (
  // clock and reset
  input wire clock_i,
  input wire rst_n_i,
  // data
  input wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);

  genvar g;
  ////////////////////////////////////////////////////////////////////
  generate
    for (g = 0; g < W; g = g + 1)
    begin : g_bit
      reg s1_r;
      reg s2_r;
      // first stage feeds only the second
      always @(posedge clock_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
        begin
          s1_r <= RSTV[g];
          s2_r <= RSTV[g];
        end
        else
        begin
          s1_r <= d_i[g];
          s2_r <= s1_r;
        end
      end
      assign q_o[g] = s2_r;
    end
  endgenerate

endmodule // lvrs_sync

/* rtl/lvrs_top.v */
// low-voltage reset, reset cause and safe-state lock, apb slave
// assumes supply comparators and reset pin are asynchronous pins;
// cpu-side strobes (stop, timeout, illegal access) are on clock_i
// Notes on behaviour
// RQ1 - power first applied or below power-on level asserts chip reset
// RQ2 - after power-on, hold reset until supply above detect threshold
// RQ3 - power-on reset sets both power-on and low-voltage cause bits
// RQ4 - reset enable set: low voltage resets chip instead of interrupting
// RQ5 - reset enable is write-once, set by power-on, kept by other resets
// RQ6 - with reset enable set, lock bit blocks nothing
// RQ7 - low-voltage reset holds until above detect, sets low-voltage cause
// RQ8 - below detect, irq enable set, reset enable clear: vector fffa irq
// RQ9 - safe state entered only on stop with lock set and flag high
// RQ10 - lock set and below rearm: block interrupts, resets, wakeups
// RQ11 - above rearm, lock ignored for blocking but still reads one
// RQ12 - software enters stop3 or stop2 before supply reaches minimum
// RQ13 - in safe state keep ram, and processor state when in stop3
// RQ14 - supply back above rearm unblocks interrupts, resets, wakeups
// RQ15 - software clears lock bit after recovering from stop
// RQ16 - software enters safe state quickly, or uses reset mode
// RQ17 - reset vector fffe wins for watchdog, lvd, pin, opcode, address
// RQ18 - warning flag shows supply nearing detect, never interrupts
// RQ19 - lvd irq request stays while flag and enable set until acked
`timescale 1ns/1ns
`include "lvrs_map.vh"
module lvrs_top #(
  parameter AW = 8,
  parameter NIRQ = 8,
  parameter NWAKE = 4,
  parameter HOLD_CYC = `LVRS_HOLD_CYC
) (
  // clock and power-on reset
  input wire clock_i,
  input wire rstn_i,
  // apb slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [AW-1:0] paddr_i,
  input wire [31:0] pwdata_i,
  output wire [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  // supply comparators, high while condition holds
  input wire por_det_i,
  input wire undervolt_detect_i,
  input wire undervolt_warning_i,
  input wire rearm_ok_i,
  // reset sources
  input wire ext_reset_i,
  input wire reset_pin_enable_i,
  input wire wdog_timeout_i,
  input wire watchdog_enable_i,
  input wire illop_i,
  input wire illad_i,
  // cpu stop handshake
  input wire stop_exec_i,
  input wire stop3_i,
  // other interrupt and wakeup sources
  input wire [NIRQ-1:0] periph_irq_i,
  input wire [NWAKE-1:0] wake_i,
  // reset, vector and gating outputs
  output wire chip_reset_o,
  output wire [15:0] vector_o,
  output wire lvd_irq_o,
  output wire [NIRQ-1:0] periph_irq_o,
  output wire [NWAKE-1:0] wake_o,
  output wire watchdog_clear_o,
  // safe-state retention
  output wire safe_state_o,
  output wire ram_retain_o,
  output wire cpu_retain_o,
  // summary interrupt
  output wire irq_o
);

  localparam [1:0] S_RUN = 2'd0;
  localparam [1:0] S_HOLD_LV = 2'd1;
  localparam [1:0] S_HOLD_CNT = 2'd2;
  localparam CW = 16;
  localparam [CW-1:0] HOLD_LAST = HOLD_CYC[CW-1:0] - 1'b1;

  reg rst_s1_r;
  reg rst_n;
  wire por_s;
  wire lvd_s;
  wire warn_s;
  wire rearm_s;
  wire pin_s;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [CW-1:0] cnt_r;
  reg [CW-1:0] cnt_nxt;
  reg [`LVRS_CAUSE_W-1:0] cause_r;
  reg [`LVRS_CAUSE_W-1:0] cause_nxt;
  reg rst_out_r;
  reg por_evt;
  reg flag_r;
  reg ie_r;
  reg safe_r;
  reg sstate_r;
  reg stop3_r;
  reg blk_r;
  reg lvd_irq_r;
  reg [15:0] vec_r;
  reg [NIRQ-1:0] pirq_r;
  reg [NWAKE-1:0] wake_r;
  reg wdclr_r;
  reg [`LVRS_EV_W-1:0] istat_r;
  reg [`LVRS_EV_W-1:0] imask_r;
  reg [31:0] rdata_r;
  reg rearm_d_r;
  reg flag_d_r;
  wire ure;
  wire setup;
  wire acc;
  wire wr;
  wire rd;
  wire hit_ctrl;
  wire hit_cause;
  wire hit_istat;
  wire hit_imask;
  wire hit;
  wire ack;
  wire blk;
  wire rst_lvd;
  wire rst_other;
  wire rst_now;
  wire lvd_irq_nxt;
  wire [`LVRS_EV_W-1:0] ev;

  ////////////////////////////////////////////////////////////////////
  // reset release through two flops
  always @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rst_s1_r <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_n <= rst_s1_r;
    end
  end

  // pins synchronised; supply assumed low until seen otherwise
  lvrs_sync #(
    .W(5),
    .RSTV(5'h03)
  ) u_sync (
    .clock_i(clock_i),
    .rst_n_i(rst_n),
    .d_i({ext_reset_i, rearm_ok_i, undervolt_warning_i,
      undervolt_detect_i, por_det_i}),
    .q_o({pin_s, rearm_s, warn_s, lvd_s, por_s})
  );

  ////////////////////////////////////////////////////////////////////
  // apb decode; zero-wait, read data captured in setup cycle
  assign setup = psel_i & ~penable_i;
  assign acc = psel_i & penable_i;
  assign wr = acc & pwrite_i;
  assign rd = acc & ~pwrite_i;
  assign hit_ctrl = (paddr_i == `LVRS_OFS_CTRL);
  assign hit_cause = (paddr_i == `LVRS_OFS_CAUSE);
  assign hit_istat = (paddr_i == `LVRS_OFS_ISTAT);
  assign hit_imask = (paddr_i == `LVRS_OFS_IMASK);
  assign hit = hit_ctrl | hit_cause | hit_istat | hit_imask;
  assign pready_o = 1'b1;
  assign pslverr_o = acc & ~hit;
  assign prdata_o = rdata_r;
  assign ack = wr & hit_ctrl & pwdata_i[`LVRS_CTL_ACK];

  // read mux registered so the data output is a flop
  always @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
      rdata_r <= 32'h0000_0000;
    else if (setup)
    begin
      rdata_r <= 32'h0000_0000;
      if (hit_ctrl)
      begin
        rdata_r[`LVRS_CTL_FLAG] <= flag_r;
        rdata_r[`LVRS_CTL_IE] <= ie_r;
        rdata_r[`LVRS_CTL_RE] <= ure;
        // RQ11 lock still reads
        rdata_r[`LVRS_CTL_SAFE] <= safe_r;
        // RQ18 warning readable
        rdata_r[`LVRS_CTL_WARN] <= warn_s;
        rdata_r[`LVRS_CTL_SSTATE] <= sstate_r;
      end
      else if (hit_cause)
        rdata_r[`LVRS_CAUSE_W-1:0] <= cause_r;
      else if (hit_istat)
        rdata_r[`LVRS_EV_W-1:0] <= istat_r;
      else if (hit_imask)
        rdata_r[`LVRS_EV_W-1:0] <= imask_r;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // write-once reset enable, reloaded only by power-on
  // RQ5 write once
  lvrs_wonce u_re (
    .clock_i(clock_i),
    .rst_n_i(rst_n),
    .por_i(por_evt),
    .wr_i(wr & hit_ctrl),
    .wd_i(pwdata_i[`LVRS_CTL_RE]),
    .q_o(ure)
  );

  ////////////////////////////////////////////////////////////////////
  // blocking: a lock with reset mode on, or above rearm, does nothing
  // RQ10 block below rearm
  // RQ6 reset mode overrides
  assign blk = safe_r & ~ure & ~rearm_s;

  // RQ4 lvd as reset
  assign rst_lvd = lvd_s & ure & ~blk;
  // RQ17 reset sources
  assign rst_other = ~blk & ((wdog_timeout_i & watchdog_enable_i) |
    (pin_s & reset_pin_enable_i) | illop_i | illad_i);
  assign rst_now = por_s | rst_lvd | rst_other;

  ////////////////////////////////////////////////////////////////////
  // reset sequencer and cause capture
  always @*
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    cause_nxt = cause_r;
    por_evt = 1'b0;
    if (por_s)
    begin
      // RQ1 power-on reset
      // RQ3 both cause bits
      state_nxt = S_HOLD_LV;
      cause_nxt = `LVRS_CAUSE_POR;
      por_evt = 1'b1;
    end
    else
    begin
      case (state_r)
        S_RUN:
        begin
          if (rst_lvd)
          begin
            // RQ7 lvd reset cause
            state_nxt = S_HOLD_LV;
            cause_nxt = {`LVRS_CAUSE_W{1'b0}};
            cause_nxt[`LVRS_CS_POR] = cause_r[`LVRS_CS_POR];
            cause_nxt[`LVRS_CS_LVD] = 1'b1;
          end
          else if (rst_other)
          begin
            state_nxt = S_HOLD_CNT;
            cnt_nxt = {CW{1'b0}};
            cause_nxt = {`LVRS_CAUSE_W{1'b0}};
            cause_nxt[`LVRS_CS_PIN] = pin_s & reset_pin_enable_i;
            cause_nxt[`LVRS_CS_WDOG] = wdog_timeout_i & watchdog_enable_i;
            cause_nxt[`LVRS_CS_ILOP] = illop_i;
            cause_nxt[`LVRS_CS_ILAD] = illad_i;
          end
        end
        S_HOLD_LV:
        begin
          // RQ2 hold until above detect
          if (!lvd_s)
            state_nxt = S_RUN;
        end
        S_HOLD_CNT:
        begin
          cnt_nxt = cnt_r + 1'b1;
          if (cnt_r == HOLD_LAST)
            state_nxt = S_RUN;
        end
        default:
          state_nxt = S_HOLD_LV;
      endcase
    end
  end

  // power-on state: held, both cause bits set
  always @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= S_HOLD_LV;
      cnt_r <= {CW{1'b0}};
      cause_r <= `LVRS_CAUSE_POR;
      rst_out_r <= 1'b1;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      cause_r <= cause_nxt;
      rst_out_r <= (state_nxt != S_RUN);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // flag: set while below detect, set wins over acknowledge
  // RQ19 held until acked
  // RQ8 lvd interrupt
  assign lvd_irq_nxt = flag_r & ie_r & ~ure & ~blk & ~rst_out_r;

  always @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flag_r <= 1'b0;
      ie_r <= 1'b0;
      safe_r <= 1'b0;
      lvd_irq_r <= 1'b0;
      vec_r <= `LVRS_VEC_RESET;
    end
    else
    begin
      flag_r <= lvd_s | (flag_r & ~ack);
      if (por_evt)
      begin
        ie_r <= 1'b0;
        safe_r <= 1'b0;
      end
      else if (wr && hit_ctrl)
      begin
        ie_r <= pwdata_i[`LVRS_CTL_IE];
        safe_r <= pwdata_i[`LVRS_CTL_SAFE];
      end
      lvd_irq_r <= lvd_irq_nxt;
      // RQ17 reset vector first
      if (rst_now || rst_out_r)
        vec_r <= `LVRS_VEC_RESET;
      else if (lvd_irq_nxt)
        vec_r <= `LVRS_VEC_LVD;
      else
        vec_r <= `LVRS_VEC_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // safe state and gating of other interrupts and wakeups
  always @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sstate_r <= 1'b0;
      stop3_r <= 1'b0;
      blk_r <= 1'b0;
      pirq_r <= {NIRQ{1'b0}};
      wake_r <= {NWAKE{1'b0}};
      wdclr_r <= 1'b0;
    end
    else
    begin
      // RQ9 safe entry
      if (stop_exec_i && safe_r && flag_r && !ure)
      begin
        sstate_r <= 1'b1;
        stop3_r <= stop3_i;
      end
      // RQ14 unblock on rearm
      else if (rearm_s || por_evt)
        sstate_r <= 1'b0;
      blk_r <= blk;
      // RQ10 gate sources
      pirq_r <= blk ? {NIRQ{1'b0}} : periph_irq_i;
      wake_r <= blk ? {NWAKE{1'b0}} : wake_i;
      // any write to cause register kicks the watchdog
      wdclr_r <= wr & hit_cause;
    end
  end

  // RQ13 retention
  assign ram_retain_o = sstate_r;
  assign cpu_retain_o = sstate_r & stop3_r;
  assign safe_state_o = sstate_r;

  ////////////////////////////////////////////////////////////////////
  // sticky events; warning deliberately has no event
  always @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rearm_d_r <= 1'b0;
      flag_d_r <= 1'b0;
    end
    else
    begin
      rearm_d_r <= rearm_s;
      flag_d_r <= flag_r;
    end
  end

  assign ev[`LVRS_EV_DET] = flag_r & ~flag_d_r;
  assign ev[`LVRS_EV_SAFE] = stop_exec_i & safe_r & flag_r & ~ure & ~sstate_r;
  assign ev[`LVRS_EV_REARM] = rearm_s & ~rearm_d_r & sstate_r;

  // read clears only what setup reported, so no event slips between
  always @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      istat_r <= {`LVRS_EV_W{1'b0}};
      imask_r <= {`LVRS_EV_W{1'b0}};
    end
    else
    begin
      if (rd && hit_istat)
        istat_r <= (istat_r & ~rdata_r[`LVRS_EV_W-1:0]) | ev;
      else
        istat_r <= istat_r | ev;
      if (wr && hit_imask)
        imask_r <= pwdata_i[`LVRS_EV_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs
  assign chip_reset_o = rst_out_r;
  assign vector_o = vec_r;
  assign lvd_irq_o = lvd_irq_r;
  assign periph_irq_o = pirq_r;
  assign wake_o = wake_r;
  assign watchdog_clear_o = wdclr_r;
  assign irq_o = |(istat_r & imask_r);

endmodule // lvrs_top

/* rtl/lvrs_wonce.v */
// write-once control bit with power-on reload
// assumes wr_i is a single-cycle bus write strobe
`timescale 1ns/1ns
module lvrs_wonce (
  // clock and reset
  input wire clock_i,
  input wire rst_n_i,
  // power-on reload: value back to one, lock reopened
  input wire por_i,
  // bus write
  input wire wr_i,
  input wire wd_i,
  // state
  output wire q_o
);

  reg val_r;
  reg lock_r;

  ////////////////////////////////////////////////////////////////////
  // only the first write after power-on lands; other resets leave it
  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      val_r <= 1'b1;
      lock_r <= 1'b0;
    end
    else if (por_i)
    begin
      val_r <= 1'b1;
      lock_r <= 1'b0;
    end
    else if (wr_i && !lock_r)
    begin
      val_r <= wd_i;
      lock_r <= 1'b1;
    end
  end

  assign q_o = val_r;

endmodule // lvrs_wonce

/* sim/lvrs_checker.sv */
// port checker for the low-voltage reset and safe-state block
// assumes clock_i and the active-low power-on reset rstn_i of lvrs_top
`timescale 1ns/1ns
`include "lvrs_map.vh"
module lvrs_checker #(
  parameter AW = 8,
  parameter NIRQ = 8,
  parameter NWAKE = 4
) (
  // clock and reset
  input wire clock_i,
  input wire rstn_i,
  // apb
  input wire psel_i,
  input wire penable_i,
  input wire [AW-1:0] paddr_i,
  input wire pready_o,
  input wire pslverr_o,
  // supply and sources
  input wire por_det_i,
  input wire undervolt_detect_i,
  input wire rearm_ok_i,
  input wire wdog_timeout_i,
  input wire watchdog_enable_i,
  input wire stop_exec_i,
  input wire [NIRQ-1:0] periph_irq_i,
  input wire [NWAKE-1:0] wake_i,
  // outputs under watch
  input wire chip_reset_o,
  input wire [15:0] vector_o,
  input wire lvd_irq_o,
  input wire [NIRQ-1:0] periph_irq_o,
  input wire [NWAKE-1:0] wake_o,
  input wire safe_state_o,
  input wire ram_retain_o,
  input wire cpu_retain_o
);
  ////////////////////////////////////////
  // one domain, so clock and disable are given once
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rstn_i);

  // pin comparators pass two sync flops, hence the slack below
  a_por_reset: assert property (por_det_i |-> ##[1:4] chip_reset_o)
    else $error("no chip reset after power-on detect");
  a_hold_detect: assert property ($fell(chip_reset_o) |-> !$past(undervolt_detect_i, 2))
    else $error("chip reset released while below detect");
  a_reset_vec: assert property (chip_reset_o |-> vector_o == `LVRS_VEC_RESET)
    else $error("reset vector not selected");
  a_lvd_vec: assert property (lvd_irq_o && !chip_reset_o |-> vector_o == `LVRS_VEC_LVD)
    else $error("undervolt vector not selected");
  a_wdog_reset: assert property (rearm_ok_i[*3] ##0 (wdog_timeout_i && watchdog_enable_i)
    |=> chip_reset_o)
    else $error("watchdog timeout gave no reset");
  a_safe_entry: assert property ($rose(safe_state_o) |-> $past(stop_exec_i))
    else $error("safe state entered without stop");
  a_block_out: assert property (safe_state_o && !$past(rearm_ok_i) && !$past(rearm_ok_i, 2)
    |-> periph_irq_o == '0 && wake_o == '0 && !lvd_irq_o)
    else $error("source passed while blocked");
  a_unblock_out: assert property ($past(rstn_i, 3) && $past(rearm_ok_i) && $past(rearm_ok_i, 2)
    && $past(rearm_ok_i, 3) |-> periph_irq_o == $past(periph_irq_i)
    && wake_o == $past(wake_i))
    else $error("source held back above rearm");
  a_ram_retain: assert property (safe_state_o |-> ram_retain_o)
    else $error("ram retention missing in safe state");
  a_cpu_retain: assert property (cpu_retain_o |-> safe_state_o && ram_retain_o)
    else $error("cpu retention outside safe state");
  a_apb_unmapped: assert property (psel_i && penable_i && paddr_i > `LVRS_OFS_IMASK
    |-> pslverr_o && pready_o)
    else $error("unmapped access not refused");

  // main scenarios reached
  c_safe: cover property ($rose(safe_state_o));
  c_lvd_irq: cover property ($rose(lvd_irq_o));
  c_release: cover property ($fell(chip_reset_o));
endmodule // lvrs_checker

bind lvrs_top lvrs_checker #(.AW(AW), .NIRQ(NIRQ), .NWAKE(NWAKE)) u_lvrs_checker (.clock_i,
  .rstn_i, .psel_i, .penable_i, .paddr_i, .pready_o, .pslverr_o, .por_det_i,
  .undervolt_detect_i, .rearm_ok_i, .wdog_timeout_i, .watchdog_enable_i, .stop_exec_i,
  .periph_irq_i, .wake_i, .chip_reset_o, .vector_o, .lvd_irq_o, .periph_irq_o, .wake_o,
  .safe_state_o, .ram_retain_o, .cpu_retain_o);

/* sim/lvrs_supply.sv */
// supply comparator model standing in front of the low-voltage block
// assumes the bench picks a coarse supply band on lvl_i
`timescale 1ns/1ns
module lvrs_supply (
  // band: 0 below power-on, 1 below detect, 2 near detect, 3 above rearm
  input wire logic [1:0] lvl_i,
  // comparator levels, high while the condition holds
  output logic por_det_o,
  output logic det_o,
  output logic warn_o,
  output logic rearm_o
);
  ////////////////////////////////////////
  // thresholds nest, so one band sets all four levels at once
  assign por_det_o = (lvl_i == 2'd0);
  assign det_o = (lvl_i < 2'd2);
  assign warn_o = (lvl_i != 2'd3);
  assign rearm_o = (lvl_i == 2'd3);
endmodule // lvrs_supply

/* sim/testbench.sv */
// self-checking bench for the low-voltage reset and safe-state block
// assumes lvrs_top fed by the lvrs_supply comparator model
`timescale 1ns/1ns
`include "lvrs_map.vh"
module testbench;
  logic clock_i = 1'b0;
  logic rstn_i = 1'b0;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o, q;
  logic pready_o, pslverr_o, e;
  logic [1:0] lvl = 2'd3;
  logic por_det_i, undervolt_detect_i, undervolt_warning_i, rearm_ok_i;
  logic ext_reset_i = 1'b0, wdog_timeout_i = 1'b0, watchdog_enable_i = 1'b1;
  logic illop_i = 1'b0, illad_i = 1'b0, stop_exec_i = 1'b0;
  logic chip_reset_o, lvd_irq_o, safe_state_o, ram_retain_o, cpu_retain_o, irq_o;
  logic [15:0] vector_o;
  logic [7:0] periph_irq_o;
  logic [3:0] wake_o;
  logic wdclr;
  int err_total = 0;
  int checked = 0;

  ////////////////////////////////////////
  // design and far-side model
  lvrs_supply u_lvrs_supply (.lvl_i(lvl), .por_det_o(por_det_i),
    .det_o(undervolt_detect_i), .warn_o(undervolt_warning_i), .rearm_o(rearm_ok_i));
  // short hold keeps the reset stretch quick to count
  lvrs_top #(.HOLD_CYC(4)) u_lvrs_top (.clock_i, .rstn_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .por_det_i, .undervolt_detect_i,
    .undervolt_warning_i, .rearm_ok_i, .ext_reset_i, .reset_pin_enable_i(1'b1),
    .wdog_timeout_i, .watchdog_enable_i, .illop_i, .illad_i, .stop_exec_i, .stop3_i(1'b1),
    .periph_irq_i(8'ha5), .wake_i(4'h9), .chip_reset_o, .vector_o, .lvd_irq_o,
    .periph_irq_o, .wake_o, .watchdog_clear_o(wdclr), .safe_state_o, .ram_retain_o,
    .cpu_retain_o, .irq_o);

  // 50 mhz clock
  always #10 clock_i = ~clock_i;

  ////////////////////////////////////////
  task chk(input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x)
    begin
      err_total++;
      $display("MISMATCH at %0t: saw %h, want %h", $time, s, x);
    end
  endtask

  task stop_test;
    $display("checks %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // one apb transfer, held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    @(posedge clock_i);
    while (pready_o !== 1'b1)
      @(posedge clock_i);
    q = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
  endtask

  // outputs are judged at falling edges, away from launch edges
  task nc(input int n);
    repeat (n) @(negedge clock_i);
  endtask

  // bounded wait: 0 chip reset, 1 undervolt irq, else safe state
  task wt(input int k, input logic v);
    int n;
    n = 0;
    @(negedge clock_i);
    while ((k == 0 ? chip_reset_o : k == 1 ? lvd_irq_o : safe_state_o) !== v && n < 60)
    begin
      @(negedge clock_i);
      n++;
    end
    // a wait that runs out is a failure, not a quiet return
    if (n >= 60)
    begin
      err_total++;
      $display("MISMATCH at %0t: wait ran out", $time);
    end
  endtask

  // one-cycle strobe: 0 wdog, 1 pin, 2 opcode, 3 address, else stop
  task pulse(input int k);
    @(posedge clock_i);
    case (k)
      0: wdog_timeout_i <= 1'b1;
      1: ext_reset_i <= 1'b1;
      2: illop_i <= 1'b1;
      3: illad_i <= 1'b1;
      default: stop_exec_i <= 1'b1;
    endcase
    @(posedge clock_i);
    {wdog_timeout_i, ext_reset_i, illop_i, illad_i, stop_exec_i} <= 5'h0;
  endtask

  task supply(input logic [1:0] v);
    @(posedge clock_i);
    lvl <= v;
  endtask

  ////////////////////////////////////////
  task t_init;
    wt(0, 1'b0);
    rd(`LVRS_OFS_CAUSE, `LVRS_CAUSE_POR);
    apb(1'b0, `LVRS_OFS_CTRL, 32'h0);
    // flag may catch the sync start value, so it is left out
    chk(q & 32'hfffffffe, 32'h08);
    apb(1'b0, 8'h10, 32'h0);
    chk({q[30:0], e}, 32'h1);
    // a write to the cause register only kicks the watchdog
    apb(1'b1, `LVRS_OFS_CAUSE, 32'hff);
    nc(1);
    chk(wdclr, 1'b1);
    nc(1);
    chk(wdclr, 1'b0);
    rd(`LVRS_OFS_CAUSE, `LVRS_CAUSE_POR);
    $display("t_init done");
  endtask

  task t_sources;
    logic [31:0] cs [4];
    int n;
    cs = '{32'h20, 32'h40, 32'h10, 32'h08};
    for (int i = 0; i < 4; i++)
    begin
      pulse(i);
      wt(0, 1'b1);
      chk(vector_o, `LVRS_VEC_RESET);
      n = 0;
      while (chip_reset_o === 1'b1 && n < 60)
      begin
        n++;
        @(negedge clock_i);
      end
      chk(n, 4);
      rd(`LVRS_OFS_CAUSE, cs[i]);
    end
    // a disabled watchdog may not reset
    watchdog_enable_i <= 1'b0;
    pulse(0);
    nc(6);
    chk(chip_reset_o, 1'b0);
    @(posedge clock_i);
    watchdog_enable_i <= 1'b1;
    $display("t_sources done");
  endtask

  task t_lvd_reset;
    supply(2'd1);
    wt(0, 1'b1);
    chk(chip_reset_o, 1'b1);
    nc(10);
    chk({chip_reset_o, lvd_irq_o}, 2'b10);
    supply(2'd3);
    wt(0, 1'b0);
    rd(`LVRS_OFS_CAUSE, 32'h02);
    $display("t_lvd_reset done");
  endtask

  task t_irq;
    apb(1'b1, `LVRS_OFS_CTRL, 32'h06);
    apb(1'b1, `LVRS_OFS_CTRL, 32'h0c);
    rd(`LVRS_OFS_CTRL, 32'h04);
    apb(1'b0, `LVRS_OFS_ISTAT, 32'h0);
    apb(1'b1, `LVRS_OFS_IMASK, 32'h07);
    supply(2'd2);
    nc(6);
    chk({lvd_irq_o, irq_o}, 2'b00);
    rd(`LVRS_OFS_CTRL, 32'h24);
    supply(2'd1);
    wt(1, 1'b1);
    chk({chip_reset_o, lvd_irq_o, vector_o}, {2'b01, `LVRS_VEC_LVD});
    chk(irq_o, 1'b1);
    rd(`LVRS_OFS_ISTAT, 32'h1);
    rd(`LVRS_OFS_ISTAT, 32'h0);
    nc(1);
    chk({lvd_irq_o, irq_o}, 2'b10);
    $display("t_irq done");
  endtask

  task t_safe;
    // software keeps to lock, then stop, then clear once back
    apb(1'b1, `LVRS_OFS_IMASK, 32'h05);
    apb(1'b1, `LVRS_OFS_CTRL, 32'h14);
    nc(4);
    chk({periph_irq_o, wake_o, lvd_irq_o}, 13'h0);
    pulse(0);
    nc(6);
    chk(chip_reset_o, 1'b0);
    pulse(4);
    nc(1);
    chk({safe_state_o, ram_retain_o, cpu_retain_o, irq_o}, 4'he);
    rd(`LVRS_OFS_ISTAT, 32'h2);
    apb(1'b1, `LVRS_OFS_IMASK, 32'h07);
    supply(2'd3);
    wt(2, 1'b0);
    chk(safe_state_o, 1'b0);
    nc(3);
    chk({periph_irq_o, wake_o, lvd_irq_o}, {8'ha5, 4'h9, 1'b1});
    rd(`LVRS_OFS_CTRL, 32'h15);
    rd(`LVRS_OFS_ISTAT, 32'h4);
    apb(1'b1, `LVRS_OFS_CTRL, 32'h06);
    nc(3);
    chk(lvd_irq_o, 1'b0);
    // lock with a clear flag must not reach safe state
    apb(1'b1, `LVRS_OFS_CTRL, 32'h14);
    pulse(4);
    nc(2);
    chk({safe_state_o, periph_irq_o}, {1'b0, 8'ha5});
    apb(1'b1, `LVRS_OFS_CTRL, 32'h04);
    $display("t_safe done");
  endtask

  task t_por;
    supply(2'd0);
    wt(0, 1'b1);
    chk(chip_reset_o, 1'b1);
    supply(2'd3);
    wt(0, 1'b0);
    rd(`LVRS_OFS_CAUSE, `LVRS_CAUSE_POR);
    apb(1'b0, `LVRS_OFS_CTRL, 32'h0);
    chk(q & 32'hfffffffe, 32'h08);
    apb(1'b1, `LVRS_OFS_CTRL, 32'h1e);
    supply(2'd1);
    wt(0, 1'b1);
    nc(3);
    chk({chip_reset_o, periph_irq_o}, {1'b1, 8'ha5});
    supply(2'd3);
    wt(0, 1'b0);
    $display("t_por done");
  endtask

  ////////////////////////////////////////
  // main sequence, reset held for 20 cycles
  initial
  begin
    repeat (20) @(posedge clock_i);
    rstn_i <= 1'b1;
    t_init;
    t_sources;
    t_lvd_reset;
    t_irq;
    t_safe;
    t_por;
    stop_test;
  end

  // whole run needs a few hundred cycles; cut a hang well past that
  initial
  begin
    #400000;
    err_total++;
    $display("MISMATCH at %0t: run timed out", $time);
    stop_test;
  end
endmodule // testbench
